// *** mih_handler.v ***
// motion instruction handler: speed, stall tolerance, sampling, binding, displacement
`include "mih_defs.vh"
module mih_handler #(
  parameter MS_CYCLES = `MIH_MS_NS / `MIH_CLK_PERIOD_NS
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [7:0] controller_id_i,
  input wire cmd_valid_i,
  input wire [3:0] cmd_code_i,
  input wire [31:0] cmd_arg_i,
  input wire cmd_neg_i,
  output wire cmd_ready_o,
  output wire cmd_reject_o,
  output wire ack_valid_o,
  output wire [7:0] ack_byte_o,
  output wire ack_last_o,
  input wire ack_ready_i,
  input wire [15:0] ramp_acc_i,
  input wire [15:0] ramp_dec_i,
  input wire [15:0] ramp_mms_i,
  input wire [15:0] ramp_mmd_i,
  input wire [3:0] ramp_given_i,
  input wire drv_enable_i,
  input wire [31:0] encoder_count_i,
  input wire [2:0] sensor_pin_i,
  input wire cfg_pair_wr_i,
  input wire cfg_third_wr_i,
  output wire step_o,
  output wire dir_o,
  output wire pos_mode_o,
  output wire move_done_o,
  output wire stall_alarm_o,
  output wire store_req_o,
  output wire [2:0] act_group_o,
  output wire [63:0] act_ramp_o
);
  // full-width constants first, then cut on purpose to the counter widths
  localparam [31:0] CLK_HZ_FULL = `MIH_NS_PER_S / `MIH_CLK_PERIOD_NS;
  localparam [31:0] MS_LAST_FULL = MS_CYCLES - 1;
  localparam [27:0] CLK_HZ = CLK_HZ_FULL[27:0];
  localparam [17:0] MS_LAST = MS_LAST_FULL[17:0];

  // payload encoders: low byte first, sign byte last
  function [23:0] enc16;
    input neg;
    input [15:0] v;
    enc16 = {7'h00, neg, v[15:8], v[7:0]};
  endfunction
  function [39:0] enc32;
    input neg;
    input [31:0] v;
    enc32 = {7'h00, neg, v};
  endfunction
  function [71:0] samp_pay;
    input [47:0] v;
    samp_pay = {enc16(1'b0, v[47:32]), enc16(1'b0, v[31:16]), enc16(1'b0, v[15:0])};
  endfunction

  reg [15:0] speed_mag_reg, tol_reg;
  reg speed_neg_reg, pos_mode_reg, disp_neg_reg, move_done_reg;
  reg [47:0] samp_val_reg;
  reg [31:0] disp_set_reg, disp_taken_reg, pulse_cnt_reg;
  reg given_spd_reg, given_disp_reg, store_req_reg, reject_reg;
  reg [`MIH_GRP_W-1:0] grp_mem [0:7];
  reg [63:0] act_ramp_reg;
  reg [2:0] act_group_reg;
  reg [27:0] acc_reg;
  reg step_reg, dir_reg, stall_reg, ms_tick_reg;
  reg [17:0] ms_cnt_reg;
  reg cmd_ready_reg, tx_busy_reg, ack_valid_reg, ack_last_reg;
  reg [3:0] tx_idx_reg, tx_len_reg;
  reg [7:0] tx_lead_reg, tx_msg_reg, ack_byte_reg;
  reg [71:0] tx_pay_reg;
  integer i, j, k; // one loop index per process, so no index is shared

  wire accept = cmd_valid_i && cmd_ready_reg;
  wire [7:0] sel = cmd_arg_i[23:16];
  wire [2:0] bind_idx = cmd_arg_i[2:0];
  wire [`MIH_GRP_W-1:0] grp0 = grp_mem[0];
  wire [2:0] rise_w, fall_w;

  // instruction decode, range checks and ack framing
  reg dec_ok;
  reg [7:0] dec_lead, dec_msg;
  reg [3:0] dec_len;
  reg [71:0] dec_pay;
  reg [47:0] samp_new;
  always @* begin
    dec_ok = 1'b0;
    dec_lead = `MIH_LEAD_SET;
    dec_msg = 8'h00;
    dec_len = `MIH_LEN_NONE;
    dec_pay = 72'h0;
    samp_new = samp_val_reg;
    for (j = 0; j < 3; j = j + 1)
      if (sel == j)
        samp_new[16*j +: 16] = cmd_arg_i[15:0];
    case (cmd_code_i)
      `MIH_CMD_SPEED_SET: begin
        dec_ok = cmd_arg_i <= `MIH_SPEED_MAX;
        dec_msg = `MIH_MSG_SPEED_SET;
        dec_len = `MIH_LEN_16;
        dec_pay = {48'h0, enc16(cmd_neg_i, cmd_arg_i[15:0])};
      end
      `MIH_CMD_SPEED_QRY: begin
        dec_ok = 1'b1;
        dec_lead = `MIH_LEAD_QRY;
        dec_msg = `MIH_MSG_SPEED_QRY;
        dec_len = `MIH_LEN_16;
        dec_pay = {48'h0, enc16(speed_neg_reg, speed_mag_reg)};
      end
      `MIH_CMD_TOL_SET: begin
        dec_ok = cmd_arg_i <= `MIH_TOL_MAX;
        dec_msg = `MIH_MSG_TOL;
        dec_len = `MIH_LEN_32;
        dec_pay = {32'h0, enc32(1'b0, {16'h0000, cmd_arg_i[15:0]})};
      end
      `MIH_CMD_SAMP_SET: begin
        dec_ok = sel <= `MIH_SEL_MAX;
        dec_msg = `MIH_MSG_SAMP;
        dec_len = `MIH_LEN_SAMP;
        dec_pay = samp_pay(samp_new);
      end
      `MIH_CMD_SAMP_QRY: begin
        dec_ok = 1'b1;
        dec_msg = `MIH_MSG_SAMP;
        dec_len = `MIH_LEN_SAMP;
        dec_pay = samp_pay(samp_val_reg);
      end
      `MIH_CMD_STORE: begin
        dec_ok = 1'b1;
        dec_msg = `MIH_MSG_STORE;
      end
      `MIH_CMD_BIND: begin
        dec_ok = cmd_arg_i <= `MIH_BIND_MAX;
        dec_msg = `MIH_MSG_STORE;
      end
      `MIH_CMD_DISP_SET: begin
        dec_ok = cmd_arg_i <= `MIH_DISP_MAX;
        dec_msg = `MIH_MSG_DISP_SET;
        dec_len = `MIH_LEN_32;
        dec_pay = {32'h0, enc32(cmd_neg_i, cmd_arg_i)};
      end
      `MIH_CMD_DISP_QRY: begin
        dec_ok = 1'b1;
        dec_lead = `MIH_LEAD_QRY;
        dec_msg = `MIH_MSG_DISP_QRY;
        dec_len = `MIH_LEN_32;
        dec_pay = {32'h0, enc32(disp_neg_reg, disp_taken_reg)};
      end
      default: dec_ok = 1'b0;
    endcase
  end

  // group to bind: unsupplied fields fall back to the instruction group
  wire [`MIH_GRP_W-1:0] bind_grp = {
    ramp_given_i[3] ? ramp_acc_i : grp0[113:98],
    ramp_given_i[2] ? ramp_dec_i : grp0[97:82],
    ramp_given_i[1] ? ramp_mms_i : grp0[81:66],
    ramp_given_i[0] ? ramp_mmd_i : grp0[65:50],
    given_spd_reg ? {speed_neg_reg, speed_mag_reg} : grp0[49:33],
    given_disp_reg ? {disp_neg_reg, disp_set_reg} : grp0[32:0]};

  // sensor edge to motion group; the lowest sensor wins a tie
  reg trig_any;
  reg [2:0] trig_grp;
  always @* begin
    trig_any = 1'b0;
    trig_grp = 3'd0;
    for (k = 2; k >= 0; k = k - 1) begin
      if (rise_w[k] || fall_w[k]) begin
        trig_any = 1'b1;
        trig_grp = 3'd2 + {k[1:0], 1'b0} + {2'b00, fall_w[k] & ~rise_w[k]};
      end
    end
  end
  wire [`MIH_GRP_W-1:0] trig_data = grp_mem[trig_grp];

  // step rate from a phase accumulator clocked at the system rate
  wire run = drv_enable_i && speed_mag_reg != 16'h0000 &&
             (!pos_mode_reg || disp_taken_reg != disp_set_reg);
  wire [27:0] acc_sum = acc_reg + {12'h000, speed_mag_reg};
  wire step_fire = run && acc_sum >= CLK_HZ;
  wire dir_now = pos_mode_reg ? disp_neg_reg : speed_neg_reg;

  // settings, motion state and parameter groups
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_mag_reg <= 16'h0000;
      speed_neg_reg <= 1'b0;
      tol_reg <= 16'h0000;
      samp_val_reg <= 48'h0;
      pos_mode_reg <= 1'b0;
      disp_set_reg <= 32'h0000_0000;
      disp_neg_reg <= 1'b0;
      disp_taken_reg <= 32'h0000_0000;
      move_done_reg <= 1'b1;
      given_spd_reg <= 1'b0;
      given_disp_reg <= 1'b0;
      store_req_reg <= 1'b0;
      reject_reg <= 1'b0;
      act_group_reg <= 3'd0;
      act_ramp_reg <= {`MIH_DEF_ACC, `MIH_DEF_DEC, `MIH_DEF_MMS, `MIH_DEF_MMD};
      for (i = 0; i < 8; i = i + 1)
        grp_mem[i] <= {`MIH_DEF_ACC, `MIH_DEF_DEC, `MIH_DEF_MMS, `MIH_DEF_MMD, 50'h0};
    end else begin
      store_req_reg <= accept && cmd_code_i == `MIH_CMD_STORE;
      reject_reg <= accept && !dec_ok;
      if (step_fire && pos_mode_reg) begin
        disp_taken_reg <= disp_taken_reg + 32'h0000_0001;
        if (disp_taken_reg + 32'h0000_0001 == disp_set_reg)
          move_done_reg <= 1'b1;
      end
      if (accept && dec_ok) begin
        case (cmd_code_i)
          `MIH_CMD_SPEED_SET: begin
            speed_mag_reg <= cmd_arg_i[15:0];
            speed_neg_reg <= cmd_neg_i;
            given_spd_reg <= 1'b1;
          end
          `MIH_CMD_TOL_SET: tol_reg <= cmd_arg_i[15:0];
          `MIH_CMD_SAMP_SET: samp_val_reg <= samp_new;
          `MIH_CMD_BIND: begin
            grp_mem[bind_idx] <= bind_grp;
            given_spd_reg <= 1'b0;
            given_disp_reg <= 1'b0;
            if (bind_idx == act_group_reg)
              act_ramp_reg <= bind_grp[113:50];
          end
          `MIH_CMD_DISP_SET: begin
            given_disp_reg <= 1'b1;
            disp_taken_reg <= 32'h0000_0000;
            disp_set_reg <= cmd_arg_i;
            disp_neg_reg <= cmd_neg_i;
            act_group_reg <= 3'd0;
            act_ramp_reg <= grp0[113:50];
            if (cmd_arg_i == 32'h0000_0000) begin
              if (pos_mode_reg && !move_done_reg)
                speed_mag_reg <= 16'h0000;
              move_done_reg <= 1'b1;
              pos_mode_reg <= 1'b0;
            end else begin
              move_done_reg <= 1'b0;
              pos_mode_reg <= 1'b1;
            end
          end
          default: ;
        endcase
      end else if (trig_any) begin
        // sensor-triggered motion takes its bound speed and displacement
        act_group_reg <= trig_grp;
        act_ramp_reg <= trig_data[113:50];
        speed_neg_reg <= trig_data[49];
        speed_mag_reg <= trig_data[48:33];
        disp_neg_reg <= trig_data[32];
        disp_set_reg <= trig_data[31:0];
        disp_taken_reg <= 32'h0000_0000;
        pos_mode_reg <= trig_data[31:0] != 32'h0000_0000;
        move_done_reg <= trig_data[31:0] == 32'h0000_0000;
      end
    end
  end

  // stall check: magnitude of encoder minus pulse count
  wire [32:0] diff = {encoder_count_i[31], encoder_count_i} - {pulse_cnt_reg[31], pulse_cnt_reg};
  wire [32:0] diff_abs = diff[32] ? (33'h0 - diff) : diff;

  // step generation, pulse counter, alarm and ms divider
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg <= 28'h000_0000;
      step_reg <= 1'b0;
      dir_reg <= 1'b0;
      pulse_cnt_reg <= 32'h0000_0000;
      stall_reg <= 1'b0;
      ms_cnt_reg <= 18'h0_0000;
      ms_tick_reg <= 1'b0;
    end else begin
      if (!run)
        acc_reg <= 28'h000_0000;
      else if (step_fire)
        acc_reg <= acc_sum - CLK_HZ;
      else
        acc_reg <= acc_sum;
      step_reg <= step_fire;
      dir_reg <= dir_now;
      if (step_fire)
        pulse_cnt_reg <= dir_now ? pulse_cnt_reg - 32'h0000_0001 : pulse_cnt_reg + 32'h0000_0001;
      stall_reg <= diff_abs > {17'h0_0000, tol_reg};
      ms_tick_reg <= ms_cnt_reg == MS_LAST;
      ms_cnt_reg <= (ms_cnt_reg == MS_LAST) ? 18'h0_0000 : ms_cnt_reg + 18'h0_0001;
    end
  end

  // ack byte stream: lead, id, message, payload, tail
  wire [6:0] pay_sh = {tx_idx_reg - `MIH_PRE_BYTES, 3'b000};
  wire [71:0] pay_shifted = tx_pay_reg >> pay_sh;
  reg [7:0] frame_byte;
  always @* begin
    if (tx_idx_reg == 4'h0)
      frame_byte = tx_lead_reg;
    else if (tx_idx_reg == 4'h1)
      frame_byte = controller_id_i;
    else if (tx_idx_reg == 4'h2)
      frame_byte = tx_msg_reg;
    else if (tx_idx_reg < `MIH_PRE_BYTES + tx_len_reg)
      frame_byte = pay_shifted[7:0];
    else
      frame_byte = `MIH_TAIL;
  end

  // ack sender; one instruction in flight, rejects send nothing
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_ready_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      tx_len_reg <= 4'h0;
      tx_lead_reg <= 8'h00;
      tx_msg_reg <= 8'h00;
      tx_pay_reg <= 72'h0;
      ack_valid_reg <= 1'b0;
      ack_byte_reg <= 8'h00;
      ack_last_reg <= 1'b0;
    end else if (!tx_busy_reg) begin
      cmd_ready_reg <= !(accept && dec_ok);
      if (accept && dec_ok) begin
        tx_busy_reg <= 1'b1;
        tx_idx_reg <= 4'h0;
        tx_len_reg <= dec_len;
        tx_lead_reg <= dec_lead;
        tx_msg_reg <= dec_msg;
        tx_pay_reg <= dec_pay;
      end
    end else if (!ack_valid_reg || ack_ready_i) begin
      if (ack_valid_reg && ack_last_reg) begin
        ack_valid_reg <= 1'b0;
        ack_last_reg <= 1'b0;
        tx_busy_reg <= 1'b0;
        cmd_ready_reg <= 1'b1;
      end else begin
        ack_valid_reg <= 1'b1;
        ack_byte_reg <= frame_byte;
        ack_last_reg <= tx_idx_reg == `MIH_PRE_BYTES + tx_len_reg;
        tx_idx_reg <= tx_idx_reg + 4'h1;
      end
    end
  end

  // per-sensor samplers; sensors 0 and 1 share the pair config
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sens
      mih_sampler u_samp (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(sensor_pin_i[g]),
        .ms_tick_i(ms_tick_reg),
        .hold_ms_i(samp_val_reg[16*g +: 16]),
        .rearm_i(g < 2 ? cfg_pair_wr_i : cfg_third_wr_i),
        .rise_o(rise_w[g]),
        .fall_o(fall_w[g])
      );
    end
  endgenerate

  assign cmd_ready_o = cmd_ready_reg;
  assign cmd_reject_o = reject_reg;
  assign ack_valid_o = ack_valid_reg;
  assign ack_byte_o = ack_byte_reg;
  assign ack_last_o = ack_last_reg;
  assign step_o = step_reg;
  assign dir_o = dir_reg;
  assign pos_mode_o = pos_mode_reg;
  assign move_done_o = move_done_reg;
  assign stall_alarm_o = stall_reg;
  assign store_req_o = store_req_reg;
  assign act_group_o = act_group_reg;
  assign act_ramp_o = act_ramp_reg;
endmodule // mih_handler

// *** mih_defs.vh ***
// constants for the motion instruction handler
`ifndef MIH_DEFS_VH
`define MIH_DEFS_VH

// instruction codes on the command port
`define MIH_CMD_SPEED_SET 4'h0
`define MIH_CMD_SPEED_QRY 4'h1
`define MIH_CMD_TOL_SET 4'h2
`define MIH_CMD_SAMP_SET 4'h3
`define MIH_CMD_SAMP_QRY 4'h4
`define MIH_CMD_STORE 4'h5
`define MIH_CMD_BIND 4'h6
`define MIH_CMD_DISP_SET 4'h7
`define MIH_CMD_DISP_QRY 4'h8

// frame bytes and message identifiers
`define MIH_LEAD_SET 8'hAA
`define MIH_LEAD_QRY 8'hCC
`define MIH_TAIL 8'hFF
`define MIH_MSG_SPEED_SET 8'hB5
`define MIH_MSG_SPEED_QRY 8'hB2
`define MIH_MSG_TOL 8'hB8
`define MIH_MSG_SAMP 8'hC9
`define MIH_MSG_STORE 8'hD1
`define MIH_MSG_DISP_SET 8'hB6
`define MIH_MSG_DISP_QRY 8'hB3

// payload lengths and preamble length, in bytes
`define MIH_LEN_NONE 4'h0
`define MIH_LEN_16 4'h3
`define MIH_LEN_32 4'h5
`define MIH_LEN_SAMP 4'h9
`define MIH_PRE_BYTES 4'h3

// argument limits
`define MIH_SPEED_MAX 32'h0000_FFFF
`define MIH_TOL_MAX 32'h0000_FFFF
`define MIH_SEL_MAX 8'h02
`define MIH_BIND_MAX 32'h0000_0007
`define MIH_DISP_MAX 32'h7FFF_FFFF
`define MIH_SAMP_SINGLE 16'hEA60

// default instruction-controlled group
`define MIH_DEF_ACC 16'h012C
`define MIH_DEF_DEC 16'h012C
`define MIH_DEF_MMS 16'h0000
`define MIH_DEF_MMD 16'h0000
`define MIH_GRP_W 114

// timing
`define MIH_CLK_PERIOD_NS 32'h0000_0005
`define MIH_NS_PER_S 32'h3B9A_CA00
`define MIH_MS_NS 32'h000F_4240

`endif

// *** mih_sampler.v ***
// one digital sensor input: sync, debounce hold-off and single-shot arming
`include "mih_defs.vh"
module mih_sampler (
  input wire clk_i,
  input wire rst_n_i,
  input wire pin_i,
  input wire ms_tick_i,
  input wire [15:0] hold_ms_i,
  input wire rearm_i,
  output wire rise_o,
  output wire fall_o
);
  reg s1_reg, s2_reg, s3_reg, level_reg, armed_reg, rise_reg, fall_reg;
  reg [15:0] elapsed_reg;
  wire single = hold_ms_i > `MIH_SAMP_SINGLE;
  wire change = (s2_reg == s3_reg) && (s2_reg != level_reg);
  // hold-off is counted in whole ms ticks, so it may run up to 1 ms short
  wire accept = change && armed_reg && (single || elapsed_reg >= hold_ms_i);

  // three-stage synchroniser; only stages two and three are compared
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level tracking, edge acceptance and hold-off timer
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 1'b0;
      armed_reg <= 1'b1;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      elapsed_reg <= 16'hFFFF;
    end else begin
      if (change)
        level_reg <= s2_reg;
      rise_reg <= accept && s2_reg;
      fall_reg <= accept && !s2_reg;
      if (accept)
        elapsed_reg <= 16'h0000;
      else if (ms_tick_i && elapsed_reg != 16'hFFFF)
        elapsed_reg <= elapsed_reg + 16'h0001;
      // a config write re-arms and wins over a same-cycle disarm
      if (rearm_i)
        armed_reg <= 1'b1;
      else if (accept && single)
        armed_reg <= 1'b0;
    end
  end

  assign rise_o = rise_reg;
  assign fall_o = fall_reg;
endmodule // mih_sampler

// *** mih_handler_sva.sv ***
// port checker for the motion instruction handler
`include "mih_defs.vh"
module mih_handler_sva #(
  parameter MS_CYCLES = 20
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  input wire cmd_ready_o,
  input wire cmd_reject_o,
  input wire ack_valid_o,
  input wire [7:0] ack_byte_o,
  input wire ack_last_o,
  input wire ack_ready_i,
  input wire drv_enable_i,
  input wire step_o,
  input wire pos_mode_o,
  input wire move_done_o,
  input wire store_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // taken instruction: refused next cycle, else answered a cycle later
  a_take_answer: assert property (cmd_valid_i && cmd_ready_o |=>
    (cmd_reject_o && cmd_ready_o) or (!cmd_ready_o ##1 ack_valid_o))
    else $error("instruction not answered in time");
  a_reject_quiet: assert property (cmd_reject_o |-> !ack_valid_o [*2])
    else $error("refused instruction produced a frame");
  // a stalled sink must see the same byte
  a_ack_hold: assert property (ack_valid_o && !ack_ready_i |=> ack_valid_o && $stable(ack_byte_o)
    && $stable(ack_last_o)) else $error("ack byte changed while stalled");
  a_frame_lead: assert property ($rose(ack_valid_o) |-> ack_byte_o == `MIH_LEAD_SET
    || ack_byte_o == `MIH_LEAD_QRY) else $error("frame lead byte wrong");
  a_tail_byte: assert property (ack_valid_o && ack_last_o |-> ack_byte_o == `MIH_TAIL)
    else $error("tail byte wrong");
  a_tail_free: assert property (ack_valid_o && ack_last_o && ack_ready_i |=> !ack_valid_o && cmd_ready_o)
    else $error("not ready after tail");
  a_store_ack: assert property (store_req_o |=> ack_valid_o && ack_byte_o == `MIH_LEAD_SET && !store_req_o)
    else $error("store pulse without ack");
  // finished position move must not step
  a_done_quiet: assert property (move_done_o && pos_mode_o |=> !step_o)
    else $error("step after move done");
  a_enable_gate: assert property (!drv_enable_i [*2] |-> !step_o)
    else $error("step with driver disabled");
endmodule // mih_handler_sva

bind mih_handler mih_handler_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (
  .clk_i, .rst_n_i, .cmd_valid_i, .cmd_ready_o, .cmd_reject_o, .ack_valid_o, .ack_byte_o,
  .ack_last_o, .ack_ready_i, .drv_enable_i, .step_o, .pos_mode_o, .move_done_o, .store_req_o
);

// *** mih_host_model.sv ***
// host model: offers instructions and drains ack frames
`include "mih_defs.vh"
module mih_host_model #(
  parameter int PAUSE_CYC = 40
) (
  input wire clk_i,
  input wire slow_i,
  input wire cmd_ready_i,
  input wire cmd_reject_i,
  input wire ack_valid_i,
  input wire [7:0] ack_byte_i,
  input wire ack_last_i,
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o,
  output logic [31:0] cmd_arg_o,
  output logic cmd_neg_o,
  output logic ack_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] frame [0:255];
  int nb = 0;
  int base = 0;
  logic rej = 1'b0;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 4'h0;
    cmd_arg_o = 32'h0000_0000;
    cmd_neg_o = 1'b0;
  end
  // slow mode stalls every other cycle to exercise byte hold
  always @(posedge clk_i) ack_ready_o <= slow_i ? ~ack_ready_o : 1'b1;
  always @(posedge clk_i) begin
    if (ack_valid_i && ack_ready_o) begin
      frame[nb[7:0]] <= ack_byte_i;
      nb <= nb + 1;
    end
  end
  // hold request until taken; the released argument shows inverted junk
  task automatic send(input logic [3:0] c, input logic [31:0] a, input logic n);
    @(posedge clk_i);
    base = nb;
    cmd_code_o <= c;
    cmd_arg_o <= a;
    cmd_neg_o <= n;
    cmd_valid_o <= 1'b1;
    @(negedge clk_i);
    while (cmd_ready_i !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_arg_o <= ~a;
    @(negedge clk_i);
    rej = cmd_reject_i;
    if (rej !== 1'b1) begin
      while (!(ack_valid_i && ack_last_i && ack_ready_o)) @(negedge clk_i);
      @(posedge clk_i);
      @(negedge clk_i);
    end
    // pause scaled down from the real store time
    if (c == `MIH_CMD_STORE || c == `MIH_CMD_BIND) repeat (PAUSE_CYC) @(posedge clk_i);
  endtask
endmodule // mih_host_model

// *** tb.sv ***
// self-checking bench for the motion instruction handler
`include "mih_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h5A;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic slow = 1'b0;
  logic drv_enable_i = 1'b0;
  logic cfg_pair_wr_i = 1'b0;
  logic cfg_third_wr_i = 1'b0;
  logic [31:0] encoder_count_i = 32'h0000_0000;
  logic [2:0] sensor_pin_i = 3'h0;
  logic [3:0] ramp_given_i = 4'h0;
  logic [15:0] ramp_acc_i = 16'h0000;
  wire cmd_valid_i, cmd_neg_i, cmd_ready_o, cmd_reject_o, ack_valid_o, ack_last_o, ack_ready_i;
  wire step_o, dir_o, pos_mode_o, move_done_o, stall_alarm_o, store_req_o;
  wire [3:0] cmd_code_i;
  wire [31:0] cmd_arg_i;
  wire [7:0] ack_byte_o;
  wire [2:0] act_group_o;
  wire [63:0] act_ramp_o;
  int bad_count = 0;
  int samples_checked = 0;
  int nsteps = 0;
  int nstores = 0;
  always #2.5 clk_i = ~clk_i;
  // step tally
  always @(posedge clk_i) if (step_o) nsteps <= nsteps + 1;
  // store pulse tally
  always @(posedge clk_i) if (store_req_o) nstores <= nstores + 1;
  mih_handler #(.MS_CYCLES(20)) DUT (
    .clk_i, .rst_n_i, .controller_id_i(ID), .cmd_valid_i, .cmd_code_i, .cmd_arg_i, .cmd_neg_i,
    .cmd_ready_o, .cmd_reject_o, .ack_valid_o, .ack_byte_o, .ack_last_o, .ack_ready_i, .ramp_acc_i,
    .ramp_dec_i(16'h0010), .ramp_mms_i(16'h0020), .ramp_mmd_i(16'h0030), .ramp_given_i,
    .drv_enable_i, .encoder_count_i, .sensor_pin_i, .cfg_pair_wr_i, .cfg_third_wr_i,
    .step_o, .dir_o, .pos_mode_o, .move_done_o, .stall_alarm_o, .store_req_o, .act_group_o, .act_ramp_o
  );
  mih_host_model host (
    .clk_i, .slow_i(slow), .cmd_ready_i(cmd_ready_o), .cmd_reject_i(cmd_reject_o),
    .ack_valid_i(ack_valid_o), .ack_byte_i(ack_byte_o), .ack_last_i(ack_last_o),
    .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_arg_o(cmd_arg_i),
    .cmd_neg_o(cmd_neg_i), .ack_ready_o(ack_ready_i)
  );
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // whole frame: lead, id, msg, payload low byte first, tail
  task automatic frm(input logic [7:0] ld, input logic [7:0] ms, input logic [71:0] p, input int n);
    int b;
    b = host.base;
    chk(host.nb - b, n + 4);
    chk(host.frame[b], ld);
    chk(host.frame[b + 1], ID);
    chk(host.frame[b + 2], ms);
    for (int i = 0; i < n; i++) chk(host.frame[b + 3 + i], p[8 * i +: 8]);
    chk(host.frame[b + 3 + n], `MIH_TAIL);
  endtask
  task automatic swait(input int lim);
    int s;
    s = nsteps;
    repeat (lim) if (nsteps == s) @(negedge clk_i);
  endtask
  task automatic dwait;
    repeat (15000) if (move_done_o !== 1'b1) @(negedge clk_i);
    // the last step pulse lands in the tally one cycle after done rises
    repeat (2) @(negedge clk_i);
  endtask
  task automatic pin(input int k, input logic v);
    @(posedge clk_i);
    sensor_pin_i[k] <= v;
    repeat (12) @(negedge clk_i);
  endtask
  task automatic t_stall;
    host.send(`MIH_CMD_TOL_SET, 32'h0000_0005, 1'b0);
    frm(`MIH_LEAD_SET, `MIH_MSG_TOL, 72'h05, 5);
    host.send(`MIH_CMD_TOL_SET, 32'h0001_0000, 1'b0);
    chk(host.rej, 1'b1);
    host.send(4'hF, 32'h0000_0000, 1'b0);
    chk(host.rej, 1'b1);
    @(posedge clk_i);
    encoder_count_i <= 32'h0000_0006;
    repeat (3) @(negedge clk_i);
    chk(stall_alarm_o, 1'b1);
    @(posedge clk_i);
    encoder_count_i <= 32'h0000_0005;
    repeat (3) @(negedge clk_i);
    chk(stall_alarm_o, 1'b0);
    host.send(`MIH_CMD_TOL_SET, 32'h0000_FFFF, 1'b0);
    frm(`MIH_LEAD_SET, `MIH_MSG_TOL, 72'hFF_FF, 5);
  endtask
  task automatic t_speed;
    int s;
    slow <= 1'b1;
    host.send(`MIH_CMD_SPEED_SET, 32'h0000_FFFF, 1'b1);
    frm(`MIH_LEAD_SET, `MIH_MSG_SPEED_SET, 72'h01_FFFF, 3);
    host.send(`MIH_CMD_SPEED_QRY, 32'h0000_0000, 1'b0);
    frm(`MIH_LEAD_QRY, `MIH_MSG_SPEED_QRY, 72'h01_FFFF, 3);
    slow <= 1'b0;
    host.send(`MIH_CMD_SPEED_SET, 32'h0001_0000, 1'b0);
    chk(host.rej, 1'b1);
    @(posedge clk_i);
    drv_enable_i <= 1'b1;
    swait(4000);
    chk(nsteps > 0, 1'b1);
    chk(dir_o, 1'b1);
    host.send(`MIH_CMD_SPEED_SET, 32'h0000_0000, 1'b0);
    s = nsteps;
    repeat (4000) @(negedge clk_i);
    chk(nsteps, s);
  endtask
  task automatic t_disp;
    int s;
    host.send(`MIH_CMD_SPEED_SET, 32'h0000_FFFF, 1'b0);
    host.send(`MIH_CMD_DISP_SET, 32'h0000_0003, 1'b0);
    s = nsteps;
    frm(`MIH_LEAD_SET, `MIH_MSG_DISP_SET, 72'h03, 5);
    chk(pos_mode_o, 1'b1);
    dwait();
    chk(nsteps - s, 3);
    chk(dir_o, 1'b0);
    host.send(`MIH_CMD_DISP_QRY, 32'h0000_0000, 1'b0);
    frm(`MIH_LEAD_QRY, `MIH_MSG_DISP_QRY, 72'h03, 5);
    host.send(`MIH_CMD_DISP_SET, 32'h0000_0064, 1'b0);
    swait(4000);
    host.send(`MIH_CMD_DISP_SET, 32'h0000_0002, 1'b0);
    s = nsteps;
    dwait();
    chk(nsteps - s, 2);
    host.send(`MIH_CMD_DISP_SET, 32'h0000_0064, 1'b0);
    swait(4000);
    host.send(`MIH_CMD_DISP_SET, 32'h0000_0000, 1'b0);
    chk({move_done_o, pos_mode_o}, 2'h2);
    s = nsteps;
    repeat (4000) @(negedge clk_i);
    chk(nsteps, s);
    host.send(`MIH_CMD_DISP_SET, 32'h8000_0000, 1'b0);
    chk(host.rej, 1'b1);
  endtask
  task automatic t_bind;
    @(posedge clk_i);
    drv_enable_i <= 1'b0;
    host.send(`MIH_CMD_STORE, 32'h0000_0000, 1'b0);
    frm(`MIH_LEAD_SET, `MIH_MSG_STORE, 72'h00, 0);
    chk(nstores, 1);
    host.send(`MIH_CMD_BIND, 32'h0000_0008, 1'b0);
    chk(host.rej, 1'b1);
    for (int k = 0; k < 8; k++) begin
      host.send(`MIH_CMD_BIND, k, 1'b0);
      frm(`MIH_LEAD_SET, `MIH_MSG_STORE, 72'h00, 0);
    end
    chk(nstores, 1);
    @(posedge clk_i);
    ramp_acc_i <= 16'h0064;
    ramp_given_i <= 4'h8;
    host.send(`MIH_CMD_BIND, 32'h0000_0002, 1'b0);
    @(posedge clk_i);
    ramp_given_i <= 4'h0;
  endtask
  task automatic t_samp;
    host.send(`MIH_CMD_SAMP_SET, 32'h0000_FFFF, 1'b0);
    host.send(`MIH_CMD_SAMP_SET, 32'h0001_0003, 1'b0);
    host.send(`MIH_CMD_SAMP_SET, 32'h0002_0000, 1'b0);
    host.send(`MIH_CMD_SAMP_SET, 32'h0003_0000, 1'b0);
    chk(host.rej, 1'b1);
    host.send(`MIH_CMD_SAMP_QRY, 32'h0000_0000, 1'b0);
    frm(`MIH_LEAD_SET, `MIH_MSG_SAMP, 72'h00_0000_0000_0300_FFFF, 9);
    pin(0, 1'b1);
    chk(act_group_o, 3'h2);
    chk(act_ramp_o, 64'h0064_012C_0000_0000);
    pin(0, 1'b0);
    chk(act_group_o, 3'h2);
    host.send(`MIH_CMD_SAMP_SET, 32'h0000_0000, 1'b0);
    @(posedge clk_i);
    cfg_pair_wr_i <= 1'b1;
    cfg_third_wr_i <= 1'b1;
    @(posedge clk_i);
    cfg_pair_wr_i <= 1'b0;
    cfg_third_wr_i <= 1'b0;
    pin(0, 1'b1);
    pin(0, 1'b0);
    chk(act_group_o, 3'h3);
    pin(1, 1'b1);
    chk(act_group_o, 3'h4);
    pin(1, 1'b0);
    chk(act_group_o, 3'h4);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog sized well above the longest motion waits
  initial begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk(act_ramp_o, 64'h012C_012C_0000_0000);
    chk(move_done_o, 1'b1);
    t_stall();
    t_speed();
    t_disp();
    t_bind();
    t_samp();
    report_and_stop();
  end
endmodule // tb
